/* frame_ram.sv */
// byte-wide frame storage with registered read data
`timescale 1ns/100ps
module frame_ram (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [8:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [8:0] raddr,
	output logic      [7:0] rdata
);
	logic [7:0] mem [0:sfifo_pkg::DEPTH-1];

	// no reset on the array; content is only visible through the count
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // frame_ram

/* meas_source.sv */
// measurement engine model feeding results into the frame buffer
`timescale 1ns/100ps
module meas_source #(
	parameter logic [23:0] TIME_VAL = 24'h5A_3C71
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       fire,
	output logic            valid,
	output sfifo_pkg::meas_t meas,
	output logic [23:0]     stime
);
	// one-cycle result pulse; the bus wanders between results so that
	// a late sample of stale data shows up as a wrong byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid <= 1'b0;
			meas  <= '0;
		end else if (fire) begin
			valid <= 1'b1;
			meas  <= {$urandom, $urandom, $urandom};
		end else begin
			valid <= 1'b0;
			meas  <= ~meas;
		end
	end

	// time held still so the appended time frame is predictable
	assign stime = TIME_VAL;
endmodule // meas_source

/* sensor_result_fifo_input_tb.sv */
// self-checking bench of the frame buffer write side and byte count
`timescale 1ns/100ps
module sensor_result_fifo_input_tb;
	logic             MCLK, RESET_N, PSEL, PENABLE, PWRITE, fire;
	logic [7:0]       PADDR;
	logic [31:0]      PWDATA, PRDATA, rdat;
	logic             PREADY, PSLVERR, MEAS_VALID, IRQ, serr;
	sfifo_pkg::meas_t MEAS, m;
	logic [23:0]      SENSOR_TIME;
	logic [5:0]       c;
	int               err_count, tests_run, cnt, used, ln;
	logic [7:0]       bq[$];
	int               fl[$];
	logic [7:0]       tq[8];
	logic [7:0]       regs[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
	logic [31:0]      off[3] = '{32'h6, 32'h1, 32'h30};

	sfifo_top dut (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.MEAS_VALID(MEAS_VALID), .MEAS(MEAS), .SENSOR_TIME(SENSOR_TIME),
		.IRQ(IRQ));
	meas_source src (.clk(MCLK), .rst_n(RESET_N), .fire(fire),
		.valid(MEAS_VALID), .meas(MEAS), .stime(SENSOR_TIME));

	// 10 MHz clock
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end

	// hang guard, far beyond the roughly one thousand cycles the run needs
	initial begin
		repeat (20000) @(posedge MCLK);
		err_count++;
		report_and_stop;
	end

	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one apb transfer; data taken at the edge where pready is seen
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		rdat = PRDATA;
		serr = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask

	task chk_cnt;
		apb(1'b0, sfifo_pkg::OFS_CNT_LO, 32'h0);
		check("cnt_lo", rdat, 32'(cnt % 256));
		apb(1'b0, sfifo_pkg::OFS_CNT_HI, 32'h0);
		check("cnt_hi", rdat, 32'(cnt / 256));
	endtask

	// ask the engine for one result and keep what it offered
	task shoot;
		fire <= 1'b1;
		@(posedge MCLK);
		fire <= 1'b0;
		@(posedge MCLK);
		m = MEAS;
	endtask

	// model of the frame that the buffer should store
	task push(input logic [5:0] k);
		logic [23:0] t, p;
		t = (k[5:4] == sfifo_pkg::SRC_FILT) ? m.temp_filt : m.temp_raw;
		p = (k[5:4] == sfifo_pkg::SRC_FILT) ? m.press_filt : m.press_raw;
		bq.push_back({sfifo_pkg::HDR_SENSOR, 1'b0, k[2], 1'b0, k[1], 2'b00});
		for (int i = 0; i < 3; i++)
			if (k[2]) bq.push_back(t[8*i +: 8]);
		for (int i = 0; i < 3; i++)
			if (k[1]) bq.push_back(p[8*i +: 8]);
		ln = 1 + 3 * int'(k[2]) + 3 * int'(k[1]);
		fl.push_back(ln);
		cnt += ln;
	endtask

	initial begin
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h0;
		PWDATA = 32'h0;
		fire = 1'b0;
		RESET_N = 1'b0;
		err_count = 0;
		tests_run = 0;
		cnt = 0;
		used = 0;
		void'($urandom(32'hbdce_5c47));
		repeat (4) @(posedge MCLK);
		RESET_N <= 1'b1;
		@(posedge MCLK);
		// registers cleared, unmapped place refused
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0);
			check("reset_reg", rdat, 32'h0);
		end
		apb(1'b0, 8'h18, 32'h0);
		check("unmapped", {rdat[30:0], serr}, 32'h1);
		check("irq_reset", IRQ, 1'b0);
		$display("test reset done");
		// writing off: collect clear, or no channel chosen
		foreach (off[i]) begin
			apb(1'b1, sfifo_pkg::OFS_CTRL, off[i]);
			shoot;
			repeat (9) @(posedge MCLK);
			chk_cnt;
		end
		$display("test disabled done");
		// every source select with every channel choice
		apb(1'b1, sfifo_pkg::OFS_MASK, 32'h1);
		apb(1'b0, sfifo_pkg::OFS_MASK, 32'h0);
		check("mask_rd", rdat, 32'h1);
		for (int s = 0; s < 4; s++) begin
			for (int ch = 1; ch < 4; ch++) begin
				c = {s[1:0], 1'b0, ch[1:0], 1'b1};
				apb(1'b1, sfifo_pkg::OFS_CTRL, {26'h0, c});
				apb(1'b0, sfifo_pkg::OFS_CTRL, 32'h0);
				check("ctrl_rd", rdat, {26'h0, c});
				shoot;
				push(c);
				repeat (8) @(posedge MCLK);
				chk_cnt;
				check("irq_wr", IRQ, 1'b1);
				apb(1'b1, sfifo_pkg::OFS_STATUS, 32'h1);
				check("irq_clr", IRQ, 1'b0);
			end
		end
		$display("test frames done");
		// writing off with frames held: read all, count per frame
		apb(1'b1, sfifo_pkg::OFS_CTRL, 32'h0);
		shoot;
		repeat (9) @(posedge MCLK);
		chk_cnt;
		apb(1'b1, sfifo_pkg::OFS_MASK, 32'h2);
		while (bq.size() > 0) begin
			apb(1'b0, sfifo_pkg::OFS_DATA, 32'h0);
			check("data", rdat, {24'h0, bq.pop_front()});
			used++;
			if (used == fl[0]) begin
				cnt -= fl.pop_front();
				used = 0;
			end
			chk_cnt;
		end
		apb(1'b0, sfifo_pkg::OFS_STATUS, 32'h0);
		check("sts_rd", rdat & 32'h2, 32'h2);
		check("irq_rd", IRQ, 1'b1);
		apb(1'b1, sfifo_pkg::OFS_STATUS, 32'h7);
		$display("test readout done");
		// over-read: time frame then empty frames
		apb(1'b1, sfifo_pkg::OFS_CTRL, 32'h8);
		tq = '{sfifo_pkg::HDR_TIME, SENSOR_TIME[7:0], SENSOR_TIME[15:8],
			SENSOR_TIME[23:16], sfifo_pkg::HDR_EMPTY, sfifo_pkg::BYTE_ZERO,
			sfifo_pkg::HDR_EMPTY, sfifo_pkg::BYTE_ZERO};
		foreach (tq[i]) begin
			apb(1'b0, sfifo_pkg::OFS_DATA, 32'h0);
			check("tail", rdat, {24'h0, tq[i]});
		end
		chk_cnt;
		$display("test over-read done");
		// flush while writing is off
		apb(1'b1, sfifo_pkg::OFS_CTRL, 32'h3);
		shoot;
		push(6'h03);
		repeat (8) @(posedge MCLK);
		chk_cnt;
		apb(1'b1, sfifo_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, sfifo_pkg::OFS_CTRL, 32'h100);
		// the flush throws away everything the model still holds
		cnt = 0;
		bq.delete();
		fl.delete();
		chk_cnt;
		apb(1'b0, sfifo_pkg::OFS_DATA, 32'h0);
		check("flush_hdr", rdat, {24'h0, sfifo_pkg::HDR_EMPTY});
		apb(1'b0, sfifo_pkg::OFS_DATA, 32'h0);
		check("flush_pad", rdat, {24'h0, sfifo_pkg::BYTE_ZERO});
		$display("test flush done");
		// second result while the writer is busy is dropped
		apb(1'b1, sfifo_pkg::OFS_CTRL, 32'h7);
		shoot;
		push(6'h07);
		shoot;
		repeat (9) @(posedge MCLK);
		chk_cnt;
		apb(1'b0, sfifo_pkg::OFS_STATUS, 32'h0);
		check("drop", rdat & 32'h4, 32'h4);
		// the first result must be the one kept, untouched by the second
		while (bq.size() > 0) begin
			apb(1'b0, sfifo_pkg::OFS_DATA, 32'h0);
			check("kept", rdat, {24'h0, bq.pop_front()});
		end
		cnt -= fl.pop_front();
		chk_cnt;
		$display("test busy drop done");
		report_and_stop;
	end
endmodule // sensor_result_fifo_input_tb

/* sfifo_pkg.sv */
// shared constants, register map and carrier types of the frame buffer
package sfifo_pkg;
	// storage geometry
	localparam int       DEPTH      = 512;
	localparam int       AW         = 9;
	localparam int       CW         = 10;
	localparam logic [9:0] MAX_CNT  = 10'h1FF;
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CNT_LO = 8'h04;
	localparam logic [7:0] OFS_CNT_HI = 8'h08;
	localparam logic [7:0] OFS_DATA   = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK   = 8'h14;
	// control field positions and reset values
	localparam int       CTRL_W     = 6;
	localparam int       CTL_FLUSH  = 8;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [1:0] SRC_FILT = 2'h1;
	// status and mask layout
	localparam int       STS_W      = 3;
	localparam int       ST_WDONE   = 0;
	localparam int       ST_RDONE   = 1;
	localparam int       ST_DROP    = 2;
	localparam logic [2:0] STS_RST  = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	// frame lengths and fixed frame bytes
	localparam logic [2:0] LEN_ONE  = 3'h4;
	localparam logic [2:0] LEN_BOTH = 3'h7;
	localparam logic [1:0] HDR_SENSOR = 2'h2;
	localparam logic [7:0] HDR_TIME   = 8'hA0;
	localparam logic [7:0] HDR_EMPTY  = 8'h80;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;

	// results offered by the measurement engine
	typedef struct packed {
		logic [23:0] press_raw;
		logic [23:0] temp_raw;
		logic [23:0] press_filt;
		logic [23:0] temp_filt;
	} meas_t;

	// control register fields, bit 5 downward
	typedef struct packed {
		logic [1:0] src;
		logic       time_en;
		logic       temp_en;
		logic       press_en;
		logic       collect;
	} ctrl_t;

	typedef enum logic {
		W_IDLE = 1'b0,
		W_BUSY = 1'b1
	} wr_state_t;

	typedef enum logic [1:0] {
		G_TIME    = 2'b00,
		G_EMPTY_H = 2'b01,
		G_EMPTY_D = 2'b10
	} gen_state_t;
endpackage

/* sfifo_top.sv */
// write side, byte count and apb register file of the frame buffer
`timescale 1ns/100ps
// Behaviour
// - the buffer holds at most 511 bytes of result frames.
// - frames are collected only while collect is set, content chosen per channel.
// - writing is off when collect is zero or both channel enables are zero.
// - with writing off and bytes held, no new frame enters but the buffer works.
// - held frames stay readable with writing off, and a flush still empties it.
// - buffer status flags keep being evaluated while writing is off.
// - once all bytes are read, a time frame if enabled, then empty frames follow.
// - pressure and temperature enables act independently in any combination.
// - source select 01 stores filtered results, any other value unfiltered.
// - the 9-bit count is high register bit 0 over the low register byte.
// - the count rises only when a whole frame has been written.
// - the count falls each time a whole frame has been read.
// - each count step is a full frame length, partial values never show.
// - a two-channel frame is seven bytes, a one-channel frame four.
// - the time frame is not stored but appended after the stored data.
module sfifo_top (
	input  wire logic              MCLK,
	input  wire logic              RESET_N,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [7:0]        PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic              MEAS_VALID,
	input  wire sfifo_pkg::meas_t  MEAS,
	input  wire logic [23:0]       SENSOR_TIME,
	output logic                   IRQ
);
	sfifo_pkg::ctrl_t      ctrl_r;
	sfifo_pkg::wr_state_t  wr_st_r;
	sfifo_pkg::gen_state_t gen_st_r;
	logic [2:0]  mask_r;
	logic [2:0]  sts_r;
	logic [2:0]  sts_nxt;
	logic [9:0]  cnt_r;
	logic [9:0]  cnt_nxt;
	logic [55:0] fbuf_r;
	logic [55:0] frame_w;
	logic [2:0]  wlen_r;
	logic [2:0]  widx_r;
	logic [8:0]  wa_r;
	logic [8:0]  ra_r;
	logic [2:0]  rem_r;
	logic [2:0]  rlen_r;
	logic [1:0]  tidx_r;
	logic [23:0] time_r;
	logic        gen_r;
	logic [7:0]  q;
	logic [7:0]  gen_byte;
	logic [23:0] pd;
	logic [23:0] td;
	logic [2:0]  sel_len;
	logic [2:0]  q_len;
	logic        access;
	logic        bus_wr;
	logic        bus_rd;
	logic        hit;
	logic        flush_w;
	logic        wr_en_w;
	logic        fits;
	logic        start_w;
	logic        drop_w;
	logic        wcommit_w;
	logic        rcommit_w;
	logic        pop_w;
	logic        data_setup;

	// apb decode; every access completes without wait states
	assign access = PSEL & PENABLE;
	assign bus_wr = access & PWRITE;
	assign bus_rd = access & ~PWRITE;
	assign PREADY = 1'b1;
	always_comb begin
		if (PADDR == sfifo_pkg::OFS_CTRL) begin
			hit = 1'b1;
		end else if (PADDR == sfifo_pkg::OFS_CNT_LO) begin
			hit = 1'b1;
		end else if (PADDR == sfifo_pkg::OFS_CNT_HI) begin
			hit = 1'b1;
		end else if (PADDR == sfifo_pkg::OFS_DATA) begin
			hit = 1'b1;
		end else if (PADDR == sfifo_pkg::OFS_STATUS) begin
			hit = 1'b1;
		end else if (PADDR == sfifo_pkg::OFS_MASK) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end
	assign PSLVERR = access & ~hit;

	// control and mask registers; flush is a write-only strobe
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_r <= sfifo_pkg::CTRL_RST;
			mask_r <= sfifo_pkg::MASK_RST;
		end else if (bus_wr && PADDR == sfifo_pkg::OFS_CTRL) begin
			ctrl_r <= PWDATA[sfifo_pkg::CTRL_W-1:0];
		end else if (bus_wr && PADDR == sfifo_pkg::OFS_MASK) begin
			mask_r <= PWDATA[sfifo_pkg::STS_W-1:0];
		end
	end
	assign flush_w = bus_wr && PADDR == sfifo_pkg::OFS_CTRL
		&& PWDATA[sfifo_pkg::CTL_FLUSH];

	// writing is off unless collect and at least one channel are set
	assign wr_en_w = ctrl_r.collect
		& (ctrl_r.press_en | ctrl_r.temp_en);

	// frame assembly: header, then temperature, then pressure, xlsb first
	assign pd = (ctrl_r.src == sfifo_pkg::SRC_FILT) ? MEAS.press_filt
		: MEAS.press_raw;
	assign td = (ctrl_r.src == sfifo_pkg::SRC_FILT) ? MEAS.temp_filt
		: MEAS.temp_raw;
	always_comb begin
		frame_w[55:48] = {sfifo_pkg::HDR_SENSOR, 1'b0, ctrl_r.temp_en,
			1'b0, ctrl_r.press_en, 2'b00};
		if (ctrl_r.temp_en && ctrl_r.press_en) begin
			frame_w[47:0] = {td[7:0], td[15:8], td[23:16],
				pd[7:0], pd[15:8], pd[23:16]};
		end else if (ctrl_r.temp_en) begin
			frame_w[47:0] = {td[7:0], td[15:8], td[23:16], 24'h00_0000};
		end else begin
			frame_w[47:0] = {pd[7:0], pd[15:8], pd[23:16], 24'h00_0000};
		end
	end
	assign sel_len = (ctrl_r.temp_en && ctrl_r.press_en)
		? sfifo_pkg::LEN_BOTH : sfifo_pkg::LEN_ONE;
	// the count must stay within 9 bits, so one byte of 512 is never used
	assign fits = (cnt_r + {7'h00, sel_len}) <= sfifo_pkg::MAX_CNT;

	// a result arriving while busy or without room is dropped whole
	assign start_w = (wr_st_r == sfifo_pkg::W_IDLE) & MEAS_VALID
		& wr_en_w & fits & ~flush_w;
	assign drop_w = MEAS_VALID & wr_en_w & ~start_w & ~flush_w;
	assign wcommit_w = (wr_st_r == sfifo_pkg::W_BUSY)
		& (widx_r == wlen_r - 3'h1) & ~flush_w;

	// write engine: one byte per clock into the ram
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_st_r <= sfifo_pkg::W_IDLE;
			fbuf_r  <= 56'h00_0000_0000_0000;
			wlen_r  <= 3'h0;
			widx_r  <= 3'h0;
			wa_r    <= 9'h000;
		end else if (flush_w) begin
			wr_st_r <= sfifo_pkg::W_IDLE;
			widx_r  <= 3'h0;
			wa_r    <= 9'h000;
		end else begin
			case (wr_st_r)
				sfifo_pkg::W_IDLE: begin
					if (start_w) begin
						fbuf_r  <= frame_w;
						wlen_r  <= sel_len;
						widx_r  <= 3'h0;
						wr_st_r <= sfifo_pkg::W_BUSY;
					end
				end
				sfifo_pkg::W_BUSY: begin
					fbuf_r <= {fbuf_r[47:0], 8'h00};
					widx_r <= widx_r + 3'h1;
					wa_r   <= wa_r + 9'h001;
					if (wcommit_w) begin
						wr_st_r <= sfifo_pkg::W_IDLE;
					end
				end
				default: begin
					wr_st_r <= sfifo_pkg::W_IDLE;
				end
			endcase
		end
	end

	frame_ram u_ram (
		.clk   (MCLK),
		.we    (wr_st_r == sfifo_pkg::W_BUSY),
		.waddr (wa_r),
		.wdata (fbuf_r[55:48]),
		.raddr (ra_r),
		.rdata (q)
	);

	// read side: ram is addressed in the setup phase, data used in access
	assign data_setup = PSEL & ~PENABLE & ~PWRITE
		& (PADDR == sfifo_pkg::OFS_DATA);
	assign pop_w = bus_rd & (PADDR == sfifo_pkg::OFS_DATA);
	assign q_len = (q[4] & q[2]) ? sfifo_pkg::LEN_BOTH : sfifo_pkg::LEN_ONE;
	assign rcommit_w = pop_w & ~gen_r & (rem_r == 3'h1) & ~flush_w;

	// source of the next byte is fixed at setup so a commit cannot tear it
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			gen_r <= 1'b1;
		end else if (data_setup) begin
			gen_r <= (cnt_r == 10'h000);
		end
	end

	// stored-frame walk; the read pointer only moves on stored bytes
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ra_r   <= 9'h000;
			rem_r  <= 3'h0;
			rlen_r <= 3'h0;
		end else if (flush_w) begin
			ra_r  <= 9'h000;
			rem_r <= 3'h0;
		end else if (pop_w && !gen_r) begin
			ra_r <= ra_r + 9'h001;
			if (rem_r == 3'h0) begin
				rem_r  <= q_len - 3'h1;
				rlen_r <= q_len;
			end else begin
				rem_r <= rem_r - 3'h1;
			end
		end
	end

	// generated frames after the stored data: time frame, then empties
	always_comb begin
		case (gen_st_r)
			sfifo_pkg::G_TIME: begin
				if (!ctrl_r.time_en) begin
					gen_byte = sfifo_pkg::HDR_EMPTY;
				end else if (tidx_r == 2'h0) begin
					gen_byte = sfifo_pkg::HDR_TIME;
				end else if (tidx_r == 2'h1) begin
					gen_byte = time_r[7:0];
				end else if (tidx_r == 2'h2) begin
					gen_byte = time_r[15:8];
				end else begin
					gen_byte = time_r[23:16];
				end
			end
			sfifo_pkg::G_EMPTY_H: begin
				gen_byte = sfifo_pkg::HDR_EMPTY;
			end
			default: begin
				gen_byte = sfifo_pkg::BYTE_ZERO;
			end
		endcase
	end

	// the time frame is armed again by each new stored frame or a flush
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			gen_st_r <= sfifo_pkg::G_TIME;
			tidx_r   <= 2'h0;
			time_r   <= 24'h00_0000;
		end else if (flush_w || wcommit_w) begin
			gen_st_r <= sfifo_pkg::G_TIME;
			tidx_r   <= 2'h0;
		end else if (pop_w && gen_r) begin
			case (gen_st_r)
				sfifo_pkg::G_TIME: begin
					if (!ctrl_r.time_en) begin
						gen_st_r <= sfifo_pkg::G_EMPTY_D;
					end else begin
						tidx_r <= tidx_r + 2'h1;
						if (tidx_r == 2'h3) begin
							gen_st_r <= sfifo_pkg::G_EMPTY_H;
						end
					end
				end
				sfifo_pkg::G_EMPTY_H: begin
					gen_st_r <= sfifo_pkg::G_EMPTY_D;
				end
				default: begin
					gen_st_r <= sfifo_pkg::G_EMPTY_H;
				end
			endcase
		end else if (data_setup && gen_st_r == sfifo_pkg::G_TIME
			&& tidx_r == 2'h0) begin
			time_r <= SENSOR_TIME; // payload sampled as the frame begins
		end
	end

	// byte count moves only by whole frame lengths
	always_comb begin
		cnt_nxt = cnt_r;
		if (wcommit_w) begin
			cnt_nxt = cnt_nxt + {7'h00, wlen_r};
		end
		if (rcommit_w) begin
			cnt_nxt = cnt_nxt - {7'h00, rlen_r};
		end
	end
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_r <= 10'h000;
		end else if (flush_w) begin
			cnt_r <= 10'h000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_comb begin
		sts_nxt = sts_r;
		if (bus_wr && PADDR == sfifo_pkg::OFS_STATUS) begin
			sts_nxt = sts_nxt & ~PWDATA[sfifo_pkg::STS_W-1:0];
		end
		sts_nxt[sfifo_pkg::ST_WDONE] = sts_nxt[sfifo_pkg::ST_WDONE] | wcommit_w;
		sts_nxt[sfifo_pkg::ST_RDONE] = sts_nxt[sfifo_pkg::ST_RDONE] | rcommit_w;
		sts_nxt[sfifo_pkg::ST_DROP]  = sts_nxt[sfifo_pkg::ST_DROP] | drop_w;
	end
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sts_r <= sfifo_pkg::STS_RST;
		end else begin
			sts_r <= sts_nxt;
		end
	end
	assign IRQ = |(sts_r & mask_r);

	// read mux; unmapped addresses read zero
	always_comb begin
		PRDATA = 32'h0000_0000;
		if (!bus_rd) begin
			PRDATA = 32'h0000_0000;
		end else if (PADDR == sfifo_pkg::OFS_CTRL) begin
			PRDATA[sfifo_pkg::CTRL_W-1:0] = ctrl_r;
		end else if (PADDR == sfifo_pkg::OFS_CNT_LO) begin
			PRDATA[7:0] = cnt_r[7:0];
		end else if (PADDR == sfifo_pkg::OFS_CNT_HI) begin
			PRDATA[0] = cnt_r[8];
		end else if (PADDR == sfifo_pkg::OFS_DATA) begin
			PRDATA[7:0] = gen_r ? gen_byte : q;
		end else if (PADDR == sfifo_pkg::OFS_STATUS) begin
			PRDATA[sfifo_pkg::STS_W-1:0] = sts_r;
		end else if (PADDR == sfifo_pkg::OFS_MASK) begin
			PRDATA[sfifo_pkg::STS_W-1:0] = mask_r;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	sequence s_quiet;
		!wcommit_w && !rcommit_w && !flush_w;
	endsequence

	a_buffer_bound: assert property (cnt_r <= sfifo_pkg::MAX_CNT)
		else $error("byte count above buffer size");
	a_no_start_off: assert property (start_w |-> ctrl_r.collect
		&& (ctrl_r.press_en || ctrl_r.temp_en))
		else $error("frame started while writing disabled");
	a_count_held_off: assert property (!wr_en_w && !wcommit_w
		&& wr_st_r == sfifo_pkg::W_IDLE |=> cnt_r <= $past(cnt_r))
		else $error("count rose while writing disabled");
	a_flush_empty: assert property (flush_w |=> cnt_r == 10'h000
		&& rem_r == 3'h0)
		else $error("flush did not empty the buffer");
	a_sticky_set: assert property (drop_w |=> sts_r[sfifo_pkg::ST_DROP]
		[*2])
		else $error("drop event lost");
	a_empty_gen: assert property (pop_w && gen_r && !wcommit_w
		&& gen_st_r == sfifo_pkg::G_EMPTY_H |-> PRDATA[7:0]
		== sfifo_pkg::HDR_EMPTY ##1 gen_st_r == sfifo_pkg::G_EMPTY_D)
		else $error("empty frame header wrong");
	a_filter_pick: assert property (start_w && ctrl_r.press_en
		&& !ctrl_r.temp_en && ctrl_r.src == sfifo_pkg::SRC_FILT
		|=> fbuf_r[47:40] == $past(MEAS.press_filt[7:0]))
		else $error("filtered pressure not stored");
	a_count_high: assert property (bus_rd
		&& PADDR == sfifo_pkg::OFS_CNT_HI |-> PRDATA == {31'h0, cnt_r[8]})
		else $error("high count register wrong");
	a_count_steady: assert property (s_quiet |=> $stable(cnt_r))
		else $error("count moved without a whole frame");
	a_frame_len: assert property (start_w |=> wlen_r
		== ((ctrl_r.press_en && ctrl_r.temp_en) ? 3'h7 : 3'h4) ##0
		(wlen_r == 3'h4 ##3 wcommit_w or wlen_r == 3'h7 ##6 wcommit_w))
		else $error("frame length wrong");
	a_time_not_stored: assert property (wr_st_r == sfifo_pkg::W_BUSY
		&& widx_r == 3'h0 |-> fbuf_r[55:54] == sfifo_pkg::HDR_SENSOR
		&& fbuf_r[53] == 1'b0)
		else $error("time frame written to the ram");
endmodule // sfifo_top
